// ===== design/fag_flash_access_guard.v
// flash access guard: key lock, supply check, one-shot, scratchpad steering
// Functional notes
// R1 - modify only with monitor enabled and selected; the device-erase command skips the monitor check
// R2 - firmware writes reset-source by whole assignment
// R3 - firmware always sets monitor flag bit
// R4 - hold interrupts pending during write/erase
// R5 - firmware disables interrupts around write-enable
// R6 - firmware re-enables monitor before modifying
// R7 - firmware uses internal oscillator while modifying
// R8 - idle wake-up within three clocks
// R9 - one-shot gives short sense-amp pulse
// R10 - one-shot active after reset, bypass bit
// R11 - 128-byte rows, row change flagged
// R12 - scratchpad select steers to 0x0000-0x03FF
// R13 - no instruction fetch from scratchpad
// R14 - scratchpad locks with all pages, device erase
// R15 - key codes A5 then F1, else lockout
// R16 - write clears bits, erase whole page
// R17 - bypass holds sense-amp enable whole cycle
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`include "fag_consts.vh"
module fag_flash_access_guard (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // cpu flash access
    input  wire        cpuRead,
    input  wire        cpuFetch,
    input  wire        cpuWrite,
    input  wire [15:0] cpuAddr,
    input  wire [7:0]  cpuWdata,
    output reg  [7:0]  cpuRdata,
    output reg         cpuFetchFault,
    output wire        cpuStall,
    // supply monitor and lock state
    input  wire        monitorEnabled,
    input  wire        allPagesLocked,
    output reg         flashErrorReset,
    // interrupts and idle
    input  wire        irqIn,
    output wire        irqOut,
    input  wire        idleWake,
    output reg         coreRun,
    // sense amp
    output wire        senseAmpEnable,
    output reg         rowChange
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg        flashWriteEnableReg, flashEraseEnableReg, scratchpadSelectReg;
    reg        bypassReg, lockoutReg, firstKeyReg, unlockedReg;
    reg [7:0]  resetSourceSelectReg;
    reg        stateReg;
    reg [7:0]  opCountReg;
    reg        devEraseReg;
    reg        pendIrqReg;
    reg [1:0]  wakeCountReg;
    reg [8:0]  lastRowReg;
    reg        readPendReg, fetchScratchReg;
    reg [10:0] opAddrReg;
    reg [7:0]  opDataReg;
    reg        opEraseReg;

    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire wrAcc  = access & pwrite;
    wire mapped = (paddr == `FAG_ADDR_CTRL) || (paddr == `FAG_ADDR_KEY) ||
                  (paddr == `FAG_ADDR_SCALE) || (paddr == `FAG_ADDR_RSTSEL) ||
                  (paddr == `FAG_ADDR_STATUS) || (paddr == `FAG_ADDR_CMD) ||
                  (paddr == `FAG_ADDR_RDATA);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // map a cpu address onto the array: scratchpad sits above main space
    function [10:0] mapAddr;
        input [15:0] a;
        input        scr;
        begin
            if (scr)
                mapAddr = {1'b1, a[9:0]}; // R12
            else
                mapAddr = {1'b0, a[9:0]};
        end
    endfunction

    wire monitorOk = monitorEnabled & resetSourceSelectReg[`FAG_BIT_MONFLAG];
    wire scrActive = scratchpadSelectReg && (cpuAddr <= `FAG_SCRATCH_TOP);
    wire [10:0] cpuMapped = mapAddr(cpuAddr, scrActive);
    // scratchpad write or erase refused when it is locked along with all pages
    wire scrLocked = scrActive & allPagesLocked; // R14
    wire modReq = cpuWrite & flashWriteEnableReg & (stateReg == ST_IDLE);

    wire [7:0] memRd;
    reg        memWr;
    reg [10:0] memWrAddr;
    reg [7:0]  memWrData;
    wire [10:0] rdA = (stateReg == ST_BUSY) ? opAddrReg : cpuMapped;

    // array write source: erase sweeps, byte write clears bits
    always @*
    begin
        memWr     = 1'b0;
        memWrAddr = opAddrReg;
        memWrData = opDataReg & memRd; // R16
        if (stateReg == ST_BUSY)
        begin
            if (opEraseReg || devEraseReg)
            begin
                memWr     = 1'b1;
                memWrAddr = opAddrReg;
                memWrData = `FAG_ERASED_BYTE; // R16
            end
            else if (opCountReg == 8'h01)
                memWr = 1'b1;
        end
    end

    fag_flash_mem uMem (
        .clk    (clk),
        .wrEn   (memWr),
        .wrAddr (memWrAddr),
        .wrData (memWrData),
        .rdAddr (rdA),
        .rdData (memRd)
    );

    // the core stalls while an operation runs
    assign cpuStall = (stateReg == ST_BUSY);
    // irqs reach the core only when idle of flash work
    assign irqOut = (stateReg == ST_IDLE) & (irqIn | pendIrqReg); // R4
    // no faster clock to time a true one-shot; the high clock phase bounds
    // the pulse so the array idles through the low phase
    assign senseAmpEnable = (cpuRead | cpuFetch) & (bypassReg | clk); // R9 R17

    // register writes, key sequence, operation sequencing
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            flashWriteEnableReg  <= 1'b0;
            flashEraseEnableReg  <= 1'b0;
            scratchpadSelectReg  <= 1'b0;
            bypassReg            <= 1'b0; // R10
            lockoutReg           <= 1'b0;
            firstKeyReg          <= 1'b0;
            unlockedReg          <= 1'b0;
            resetSourceSelectReg <= `FAG_RSTSEL_RESET;
            stateReg             <= ST_IDLE;
            opCountReg           <= 8'h00;
            devEraseReg          <= 1'b0;
            opAddrReg            <= 11'h000;
            opDataReg            <= 8'h00;
            opEraseReg           <= 1'b0;
            flashErrorReset      <= 1'b0;
            pendIrqReg           <= 1'b0;
        end
        else
        begin
            flashErrorReset <= 1'b0;
            if (wrAcc && paddr == `FAG_ADDR_CTRL)
            begin
                flashWriteEnableReg <= pwdata[`FAG_BIT_WREN];
                flashEraseEnableReg <= pwdata[`FAG_BIT_ERASEEN];
                scratchpadSelectReg <= pwdata[`FAG_BIT_SCRATCH];
            end
            else if (wrAcc && paddr == `FAG_ADDR_SCALE)
                bypassReg <= pwdata[`FAG_BIT_BYPASS]; // R10
            else if (wrAcc && paddr == `FAG_ADDR_RSTSEL)
                resetSourceSelectReg <= pwdata[7:0];
            else if (wrAcc && paddr == `FAG_ADDR_KEY && !lockoutReg)
            begin
                // key state machine: any misstep locks until reset
                if (!firstKeyReg && !unlockedReg && pwdata[7:0] == `FAG_KEY_FIRST)
                    firstKeyReg <= 1'b1; // R15
                else if (firstKeyReg && pwdata[7:0] == `FAG_KEY_SECOND)
                begin
                    firstKeyReg <= 1'b0;
                    unlockedReg <= 1'b1; // R15
                end
                else
                begin
                    lockoutReg  <= 1'b1; // R15
                    firstKeyReg <= 1'b0;
                    unlockedReg <= 1'b0;
                end
            end
            else if (wrAcc && paddr == `FAG_ADDR_CMD && pwdata == `FAG_CMD_DEVERASE
                     && stateReg == ST_IDLE)
            begin
                // whole-device erase clears the scratchpad too
                devEraseReg <= 1'b1; // R14
                unlockedReg <= 1'b0; // R15
                opAddrReg   <= 11'h000;
                stateReg    <= ST_BUSY;
            end

            // irq posted while busy is kept pending
            if (stateReg == ST_BUSY && irqIn)
                pendIrqReg <= 1'b1; // R4
            else if (stateReg == ST_IDLE)
                pendIrqReg <= 1'b0;

            case (stateReg)
                ST_IDLE:
                begin
                    if (modReq)
                    begin
                        if (!monitorOk || !unlockedReg || lockoutReg || scrLocked)
                        begin
                            flashErrorReset <= !monitorOk; // R1
                            lockoutReg      <= lockoutReg | !unlockedReg; // R15
                            unlockedReg     <= 1'b0;
                        end
                        else
                        begin
                            unlockedReg <= 1'b0; // relock after each op
                            opEraseReg  <= flashEraseEnableReg;
                            opAddrReg   <= flashEraseEnableReg ?
                                           {cpuMapped[10:`FAG_PAGE_SHIFT],
                                            9'h000} : cpuMapped; // R16
                            opDataReg   <= cpuWdata;
                            opCountReg  <= `FAG_OP_CYCLES;
                            stateReg    <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY:
                begin
                    if (devEraseReg)
                    begin
                        opAddrReg <= opAddrReg + 11'h001;
                        if (opAddrReg == 11'h7FF)
                        begin
                            devEraseReg <= 1'b0;
                            stateReg    <= ST_IDLE;
                        end
                    end
                    else if (opEraseReg)
                    begin
                        opAddrReg <= opAddrReg + 11'h001;
                        if (opAddrReg[`FAG_PAGE_SHIFT-1:0] == 9'h1FF)
                        begin
                            opEraseReg <= 1'b0;
                            stateReg   <= ST_IDLE;
                        end
                    end
                    else
                    begin
                        opCountReg <= opCountReg - 8'h01;
                        if (opCountReg == 8'h01)
                            stateReg <= ST_IDLE;
                    end
                end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // read path, row tracking, fetch guard, idle wake
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            lastRowReg      <= 9'h000;
            rowChange       <= 1'b0;
            readPendReg     <= 1'b0;
            fetchScratchReg <= 1'b0;
            cpuRdata        <= 8'h00;
            cpuFetchFault   <= 1'b0;
            coreRun         <= 1'b1;
            wakeCountReg    <= 2'h0;
            prdata          <= 32'h0000_0000;
        end
        else
        begin
            rowChange <= 1'b0;
            if ((cpuRead | cpuFetch) && stateReg == ST_IDLE)
            begin
                // a new 128-byte row costs extra read current
                rowChange  <= (cpuAddr[15:`FAG_ROW_SHIFT] != lastRowReg); // R11
                lastRowReg <= cpuAddr[15:`FAG_ROW_SHIFT];
            end
            readPendReg     <= (cpuRead | cpuFetch) & (stateReg == ST_IDLE);
            fetchScratchReg <= cpuFetch & scrActive;
            cpuFetchFault   <= cpuFetch & scrActive; // R13
            if (readPendReg)
                cpuRdata <= fetchScratchReg ? 8'h00 : memRd; // R13

            // wake from idle within a fixed short count
            if (idleWake && coreRun)
                coreRun <= 1'b0;
            else if (!coreRun)
            begin
                if (irqOut || wakeCountReg != 2'h0)
                    wakeCountReg <= wakeCountReg + 2'h1; // R8
                if (wakeCountReg == `FAG_WAKE_CYCLES - 2'h1)
                begin
                    coreRun      <= 1'b1;
                    wakeCountReg <= 2'h0;
                end
            end

            if (setup && !pwrite)
            begin
                if (paddr == `FAG_ADDR_CTRL)
                    prdata <= {29'h0, scratchpadSelectReg, flashEraseEnableReg,
                               flashWriteEnableReg};
                else if (paddr == `FAG_ADDR_SCALE)
                    prdata <= {31'h0, bypassReg};
                else if (paddr == `FAG_ADDR_RSTSEL)
                    prdata <= {24'h0, resetSourceSelectReg};
                else if (paddr == `FAG_ADDR_STATUS)
                    prdata <= {28'h0, stateReg, lockoutReg, unlockedReg, firstKeyReg};
                else if (paddr == `FAG_ADDR_RDATA)
                    prdata <= {24'h0, cpuRdata};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end
endmodule // fag_flash_access_guard

// ===== design/fag_consts.vh
// constants for the flash access guard block
`ifndef FAG_CONSTS_VH
`define FAG_CONSTS_VH
`define FAG_ADDR_CTRL        12'h000
`define FAG_ADDR_KEY         12'h004
`define FAG_ADDR_SCALE       12'h008
`define FAG_ADDR_RSTSEL      12'h00C
`define FAG_ADDR_STATUS      12'h010
`define FAG_ADDR_CMD         12'h014
`define FAG_ADDR_RDATA       12'h018
`define FAG_BIT_WREN         0
`define FAG_BIT_ERASEEN      1
`define FAG_BIT_SCRATCH      2
`define FAG_BIT_BYPASS       0
`define FAG_BIT_MONFLAG      1
`define FAG_KEY_FIRST        8'hA5
`define FAG_KEY_SECOND       8'hF1
`define FAG_RSTSEL_RESET     8'h02
`define FAG_ROW_SHIFT        7
`define FAG_SCRATCH_TOP      16'h03FF
`define FAG_OP_CYCLES        8'h10
`define FAG_WAKE_CYCLES      2'h3
`define FAG_ERASED_BYTE      8'hFF
`define FAG_PAGE_SHIFT       9
`define FAG_MEM_AW           11
`define FAG_CMD_DEVERASE     32'h0000_00DE
`endif

// ===== design/fag_flash_mem.v
// byte-wide flash array model with registered read data
`timescale 1ns/10ps
module fag_flash_mem (
    // clock
    input  wire        clk,
    // write port (data already merged by caller)
    input  wire        wrEn,
    input  wire [10:0] wrAddr,
    input  wire [7:0]  wrData,
    // read port
    input  wire [10:0] rdAddr,
    output reg  [7:0]  rdData
);
    reg [7:0] cells [0:2047];

    // single write port, registered read
    always @(posedge clk)
    begin
        if (wrEn)
            cells[wrAddr] <= wrData;
        rdData <= cells[rdAddr];
    end
endmodule // fag_flash_mem

// ===== testbench/fag_guard_assertions.sv
// port-level assertions for the flash access guard
`timescale 1ns/10ps
module fag_guard_assertions (
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    // apb
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    // cpu side and status
    input wire        cpuRead,
    input wire        cpuFetch,
    input wire        cpuWrite,
    input wire        cpuStall,
    input wire        flashErrorReset,
    input wire        irqOut,
    input wire        coreRun,
    input wire        senseAmpEnable,
    input wire        rowChange
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decoded apb access
    wire acc = psel && penable;
    wire mapped = (paddr <= 12'h018) && (paddr[1:0] == 2'h0);
    // wake-up steps: request seen, core back in time
    sequence s_wake;
        $rose(irqOut) && !coreRun;
    endsequence
    sequence s_run;
        ##[1:3] coreRun;
    endsequence
    a_ready_high: assert property (acc |-> pready)
        else $error("pready low in access");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_ferr_pulse: assert property (flashErrorReset |=> !flashErrorReset)
        else $error("error reset longer than a cycle");
    a_ferr_cause: assert property (flashErrorReset |-> $past(cpuWrite) || $past(cpuWrite, 2))
        else $error("error reset without a write");
    a_wake_bound: assert property (s_wake |-> s_run)
        else $error("wake-up too slow");
    a_sense_idle: assert property (!(cpuRead || cpuFetch || cpuWrite || cpuStall) |-> !senseAmpEnable)
        else $error("sense amp on without access");
    a_stall_len: assert property ($rose(cpuStall) |-> cpuStall[*8])
        else $error("write stall cut short");
    a_reset_state: assert property ($rose(rst_n) |-> coreRun && !cpuStall && !rowChange)
        else $error("bad state after reset");
endmodule // fag_guard_assertions

bind fag_flash_access_guard fag_guard_assertions u_chk (.clk, .rst_n, .psel, .penable,
    .paddr, .pready, .pslverr, .cpuRead, .cpuFetch, .cpuWrite, .cpuStall, .flashErrorReset,
    .irqOut, .coreRun, .senseAmpEnable, .rowChange);

// ===== testbench/fag_cpu_model.sv
// cpu core model issuing flash reads, fetches and writes
`timescale 1ns/10ps
module fag_cpu_model (
    // clock
    input  wire        clk,
    // requests
    output logic       cpuRead,
    output logic       cpuFetch,
    output logic       cpuWrite,
    output logic [15:0] cpuAddr,
    output logic [7:0] cpuWdata,
    // answers
    input  wire [7:0]  cpuRdata,
    input  wire        cpuStall
);
    // idle at time zero
    initial
    begin
        cpuRead = 1'b0;
        cpuFetch = 1'b0;
        cpuWrite = 1'b0;
        cpuAddr = 16'h0000;
        cpuWdata = 8'h00;
    end
    // level read or fetch; data settles two cycles in
    task automatic rd(input logic f, input logic [15:0] a, output logic [7:0] d);
    begin
        @(posedge clk);
        cpuRead <= !f;
        cpuFetch <= f;
        cpuAddr <= a;
        repeat (3) @(posedge clk);
        d = cpuRdata;
        cpuRead <= 1'b0;
        cpuFetch <= 1'b0;
        cpuAddr <= ~a;
    end
    endtask
    // one-cycle write; execution stalls until done
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
    begin
        @(posedge clk);
        cpuWrite <= 1'b1;
        cpuAddr <= a;
        cpuWdata <= v;
        @(posedge clk);
        cpuWrite <= 1'b0;
        cpuAddr <= ~a;
        cpuWdata <= ~v;
        repeat (2) @(posedge clk);
        while (cpuStall !== 1'b0) @(posedge clk);
    end
    endtask
endmodule // fag_cpu_model

// ===== testbench/tb_top.sv
// self-checking bench for the flash access guard
`timescale 1ns/10ps
`include "fag_consts.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_top;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        cpuRead, cpuFetch, cpuWrite, cpuFetchFault, cpuStall;
    logic [15:0] cpuAddr;
    logic [7:0]  cpuWdata, cpuRdata, d;
    logic        monitorEnabled, flashErrorReset, irqIn, irqOut, idleWake;
    logic        coreRun, senseAmpEnable, rowChange, allPagesLocked;
    int          errors = 0, checks = 0, rows = 0, ferrs = 0, faults = 0, wide = 0;
    int          irqs = 0;
    fag_flash_access_guard u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .cpuRead, .cpuFetch, .cpuWrite, .cpuAddr,
        .cpuWdata, .cpuRdata, .cpuFetchFault, .cpuStall, .monitorEnabled,
        .allPagesLocked, .flashErrorReset, .irqIn, .irqOut, .idleWake, .coreRun,
        .senseAmpEnable, .rowChange);
    fag_cpu_model u_cpu (.clk, .cpuRead, .cpuFetch, .cpuWrite, .cpuAddr, .cpuWdata,
        .cpuRdata, .cpuStall);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // pulse counters
    always @(posedge clk)
    begin
        if (rowChange === 1'b1) rows++;
        if (flashErrorReset === 1'b1) ferrs++;
        if (cpuFetchFault === 1'b1) faults++;
        if (irqOut === 1'b1) irqs++;
    end
    // late low phase: only a bypassed one-shot keeps the enable up
    always @(negedge clk)
    begin
        #2;
        if (senseAmpEnable === 1'b1) wide++;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    begin
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        `CHK("reg", e, rdv)
    end
    endtask
    task automatic rdb(input logic [15:0] a, input logic [7:0] e);
    begin
        u_cpu.rd(1'b0, a, d);
        `CHK("byte", e, d)
    end
    endtask
    task automatic key;
    begin
        wr(`FAG_ADDR_KEY, 32'hA5);
        wr(`FAG_ADDR_KEY, 32'hF1);
    end
    endtask
    task automatic prog(input logic [31:0] c, input logic [15:0] a, input logic [7:0] v);
    begin
        key();
        wr(`FAG_ADDR_CTRL, c);
        u_cpu.wr(a, v);
        wr(`FAG_ADDR_CTRL, 32'h0);
    end
    endtask
    task automatic derase;
    begin
        wr(`FAG_ADDR_CTRL, 32'h3);
        wr(`FAG_ADDR_CMD, `FAG_CMD_DEVERASE);
        repeat (2) @(posedge clk);
        while (cpuStall !== 1'b0) @(posedge clk);
        wr(`FAG_ADDR_CTRL, 32'h0);
    end
    endtask
    task automatic sleep;
    begin
        @(posedge clk);
        idleWake <= 1'b1;
        @(posedge clk);
        idleWake <= 1'b0;
        repeat (5) @(posedge clk);
    end
    endtask
    task automatic conclude;
    begin
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // watchdog sized well above the sequence length
    initial
    begin
        #1000000;
        errors++;
        conclude();
    end
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        monitorEnabled = 1'b1;
        allPagesLocked = 1'b0;
        irqIn = 1'b0;
        idleWake = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`FAG_ADDR_SCALE, 32'h0);
        rdc(`FAG_ADDR_RSTSEL, 32'h2);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK("slverr", 1'b1, err)
        wr(`FAG_ADDR_RSTSEL, 32'h2);
        key();
        rdc(`FAG_ADDR_STATUS, 32'h2);
        derase();
        prog(32'h1, 16'h0100, 8'h5A);
        rdb(16'h0100, 8'h5A);
        prog(32'h1, 16'h0100, 8'hF0);
        rdb(16'h0100, 8'h50);
        rows = 0;
        rdb(16'h017F, 8'hFF);
        rdb(16'h0180, 8'hFF);
        rdb(16'h0181, 8'hFF);
        `CHK("rows", 1, rows)
        prog(32'h3, 16'h0180, 8'h00);
        rdb(16'h0100, 8'hFF);
        prog(32'h5, 16'h0010, 8'h22);
        wr(`FAG_ADDR_CTRL, 32'h4);
        rdb(16'h0010, 8'h22);
        u_cpu.rd(1'b1, 16'h0010, d);
        `CHK("fetch", 8'h00, d)
        `CHK("fault", 1'b1, faults > 0)
        wr(`FAG_ADDR_CTRL, 32'h0);
        rdb(16'h0010, 8'hFF);
        key();
        derase();
        wr(`FAG_ADDR_CTRL, 32'h4);
        rdb(16'h0010, 8'hFF);
        allPagesLocked <= 1'b1;
        prog(32'h5, 16'h0010, 8'h00);
        wr(`FAG_ADDR_CTRL, 32'h4);
        rdb(16'h0010, 8'hFF);
        allPagesLocked <= 1'b0;
        wr(`FAG_ADDR_CTRL, 32'h0);
        wide = 0;
        u_cpu.rd(1'b0, 16'h0100, d);
        `CHK("narrow", 0, wide)
        wr(`FAG_ADDR_SCALE, 32'h1);
        u_cpu.rd(1'b0, 16'h0100, d);
        `CHK("wide", 1'b1, wide > 1)
        wr(`FAG_ADDR_SCALE, 32'h0);
        sleep();
        `CHK("idle", 1'b0, coreRun)
        irqIn <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("wake", 1'b1, coreRun)
        irqIn <= 1'b0;
        key();
        wr(`FAG_ADDR_CTRL, 32'h1);
        irqs = 0;
        fork
            u_cpu.wr(16'h0200, 8'h33);
            begin
                repeat (4) @(posedge clk);
                irqIn <= 1'b1;
                @(posedge clk);
                irqIn <= 1'b0;
                `CHK("busy irq", 1'b0, irqOut)
            end
        join
        wr(`FAG_ADDR_CTRL, 32'h0);
        `CHK("held irq", 1, irqs)
        sleep();
        `CHK("asleep", 1'b0, coreRun)
        monitorEnabled <= 1'b0;
        prog(32'h1, 16'h0100, 8'h00);
        `CHK("ferr", 1, ferrs)
        monitorEnabled <= 1'b1;
        rdb(16'h0100, 8'hFF);
        wr(`FAG_ADDR_KEY, 32'hF1);
        key();
        rdc(`FAG_ADDR_STATUS, 32'h4);
        conclude();
    end
endmodule // tb_top
